/* File: verilog/sscs_pkg.sv */
// constants, register map and enumerations for the spindle speed command select block.
// assumes a 32-bit apb master and contact inputs that arrive asynchronously from the machine controller.
//
// Notes on behaviour
// (R01) three preset picks form an index, pick 3 msb, selecting stored speed 0..7 (0..32767)
// (R02) stored speed 0 zero, all picks off and digital enable open: command follows the analog voltage input
// (R03) stored speed 0 drives the motor on run, whether analog or digital mode is set
// (R04) picks reach the block only through general inputs assigned codes 11, 12, 13
// (R05) digital enable closed: command comes from twelve parallel contact lines
// (R06) four parallel formats, bcd2, bcd3, unsigned and signed binary, one active at once
// (R07) two-digit bcd: 00 is zero, 99 is maximum, scaled by code over 99
// (R08) controller puts units on lines 1-4, tens on 5-8, lsb on line 1, closed is one
// (R09) three-digit bcd: 000 zero, 999 maximum, hundreds digit on lines 9-12
// (R10) a bcd nibble above nine keeps the previous valid digital command
// (R11) format setting: 0 signed, 1 unsigned, 2 bcd2, 3 bcd3; reset value 0
// (R12) unsigned binary: 000 zero, fff maximum, linear
// (R13) signed binary: 800 zero, above forward up to fff, below reverse up to 000

package sscs_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_PRESET = 8;
  localparam int unsigned NUM_GP_IN = 12;
  localparam int unsigned NUM_PAR_LINE = 12;
  localparam int unsigned SPEED_W = 16;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_PRESET_BASE = 8'h00;   // preset_speed_0..7 at 0x00..0x1c
  localparam logic [7:0] OFS_ASSIGN_BASE = 8'h20;   // input_function_assign 0..11 at 0x20..0x4c
  localparam logic [7:0] OFS_FORMAT = 8'h50;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h54;
  localparam logic [7:0] OFS_STATUS = 8'h58;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam logic [7:0] RST_ASSIGN = 8'h00;
  localparam logic [1:0] RST_FORMAT = 2'h0;
  localparam logic [15:0] RST_MAX_SPEED = 16'h2710;
  localparam logic [15:0] PRESET_WR_MASK = 16'h7FFF;  // settings top out at 32767

  // ==========================================================
  // general input function codes
  localparam logic [7:0] FN_PICK_BIT0 = 8'h0B;
  localparam logic [7:0] FN_PICK_BIT1 = 8'h0C;
  localparam logic [7:0] FN_PICK_BIT2 = 8'h0D;
  localparam logic [7:0] FN_DIGITAL_EN = 8'h0F;

  // ==========================================================
  // status register fields
  localparam int unsigned ST_SPEED_LSB = 0;
  localparam int unsigned ST_SOURCE_LSB = 16;
  localparam int unsigned ST_REVERSE = 18;
  localparam int unsigned ST_BAD_CODE = 19;
  localparam int unsigned ST_PICK_LSB = 24;
  localparam int unsigned ST_DIGITAL_EN = 27;

  // ==========================================================
  // parallel command formats and decode constants
  localparam logic [1:0] FMT_SIGNED = 2'h0;
  localparam logic [1:0] FMT_UNSIGNED = 2'h1;
  localparam logic [1:0] FMT_BCD2 = 2'h2;
  localparam logic [1:0] FMT_BCD3 = 2'h3;
  localparam logic [11:0] DIV_BCD2 = 12'h063;      // 99
  localparam logic [11:0] DIV_BCD3 = 12'h3E7;      // 999
  localparam logic [11:0] DIV_UNSIGNED = 12'hFFF;  // 4095
  localparam logic [11:0] SIGNED_ZERO = 12'h800;
  localparam logic [11:0] DIV_SIGNED_FWD = 12'h7FF;
  localparam logic [11:0] DIV_SIGNED_REV = 12'h800;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

  // ==========================================================
  // command source shown in status and on the port
  typedef enum logic [1:0] {
    SSCS_SRC_ANALOG = 2'h0,
    SSCS_SRC_PRESET = 2'h1,
    SSCS_SRC_DIGITAL = 2'h2
  } sscs_source_t;

endpackage : sscs_pkg

/* File: verilog/sscs_digital_decode.sv */
// decoder from the twelve parallel contact lines to a speed magnitude and direction.
// assumes lines already synchronised; purely combinational, caller registers the result.
`timescale 1ns/100ps

module sscs_digital_decode (
  input wire logic [1:0] format_i,
  input wire logic [11:0] code_i,
  input wire logic [15:0] max_speed_i,
  output logic [15:0] speed_o,
  output logic reverse_o,
  output logic valid_o
);

  logic [3:0] units;
  logic [3:0] tens;
  logic [3:0] hundreds;
  logic [11:0] value;
  logic [11:0] divisor;
  logic [27:0] product;
  logic [27:0] quotient;

  // lsb on line 1, units on lines 1-4, tens 5-8, hundreds 9-12
  assign units = code_i[3:0];     // see (R08)
  assign tens = code_i[7:4];
  assign hundreds = code_i[11:8]; // see (R09)

  always_comb begin
    value = 12'h000;
    divisor = sscs_pkg::DIV_UNSIGNED;
    reverse_o = 1'b0;
    valid_o = 1'b1;
    unique case (format_i) // see (R06)
      sscs_pkg::FMT_BCD2: begin
        // only eight lines carry the code; lines 9-12 are ignored
        // widen before the multiply so 9 * 10 cannot wrap in four bits
        value = (12'(tens) * 12'd10) + 12'(units);
        divisor = sscs_pkg::DIV_BCD2; // see (R07)
        valid_o = (units <= sscs_pkg::BCD_MAX_DIGIT) && (tens <= sscs_pkg::BCD_MAX_DIGIT); // see (R10)
      end
      sscs_pkg::FMT_BCD3: begin
        value = (12'(hundreds) * 12'd100) + (12'(tens) * 12'd10) + 12'(units);
        divisor = sscs_pkg::DIV_BCD3; // see (R09)
        valid_o = (units <= sscs_pkg::BCD_MAX_DIGIT) && (tens <= sscs_pkg::BCD_MAX_DIGIT)
                  && (hundreds <= sscs_pkg::BCD_MAX_DIGIT); // see (R10)
      end
      sscs_pkg::FMT_UNSIGNED: begin
        value = code_i;
        divisor = sscs_pkg::DIV_UNSIGNED; // see (R12)
      end
      sscs_pkg::FMT_SIGNED: begin
        // 800 is standstill; the reverse half has one step more than the forward half
        if (code_i >= sscs_pkg::SIGNED_ZERO) begin
          value = code_i - sscs_pkg::SIGNED_ZERO;
          divisor = sscs_pkg::DIV_SIGNED_FWD; // see (R13)
        end else begin
          value = sscs_pkg::SIGNED_ZERO - code_i;
          divisor = sscs_pkg::DIV_SIGNED_REV;
          reverse_o = 1'b1; // see (R13)
        end
      end
    endcase
  end

  // truncating divide matches the tabled speeds, e.g. 98 -> 9898 at 10000 max
  assign product = 28'(value) * 28'(max_speed_i);
  assign quotient = product / 28'(divisor);
  assign speed_o = quotient[15:0];

endmodule : sscs_digital_decode

/* File: verilog/sscs_speed_select.sv */
// top of the spindle speed command select block: apb registers, contact input
// synchronisers, general input function routing and command source selection.
// assumes contact inputs asynchronous to clk_i and an analog command already digitised on clk_i.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module sscs_speed_select (
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // contact inputs from the controller
  input wire logic [11:0] gp_in_i,
  input wire logic [11:0] parallel_cmd_line_i,
  input wire logic run_forward_i,
  input wire logic run_reverse_i,
  // digitised analog speed command, same clock
  input wire logic [15:0] analog_speed_i,
  // resulting command
  output logic [15:0] speed_cmd_o,
  output logic speed_reverse_o,
  output logic run_o,
  output logic [1:0] cmd_source_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [11:0] gp_s1;
    logic [11:0] gp_s2;
    logic [11:0] par_s1;
    logic [11:0] par_s2;
    logic [1:0] run_s1;
    logic [1:0] run_s2;
    logic [sscs_pkg::NUM_PRESET-1:0][15:0] preset_speed;
    logic [sscs_pkg::NUM_GP_IN-1:0][7:0] input_function_assign;
    logic [1:0] parallel_cmd_format;
    logic [15:0] max_speed;
    logic [15:0] digital_speed;
    logic digital_reverse;
    logic bad_code;
    logic [15:0] speed_cmd;
    logic speed_reverse;
    logic run;
    sscs_pkg::sscs_source_t source;
    logic [31:0] rdata;
    logic rerr;
  } sscs_state_t;

  sscs_state_t st;
  sscs_state_t next_st;

  // ==========================================================
  // function routing of general inputs
  // several inputs may carry the same code; they are or-ed
  function automatic logic fn_active(
    input logic [sscs_pkg::NUM_GP_IN-1:0][7:0] assign_tab,
    input logic [11:0] pins,
    input logic [7:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sscs_pkg::NUM_GP_IN; i++) begin
      if (assign_tab[i] == code) begin
        hit = hit | pins[i];
      end
    end
    return hit;
  endfunction : fn_active

  logic [2:0] pick;
  logic digital_en;
  logic [15:0] dec_speed;
  logic dec_reverse;
  logic dec_valid;
  logic [15:0] preset_sel;

  always_comb begin
    pick[0] = fn_active(st.input_function_assign, st.gp_s2, sscs_pkg::FN_PICK_BIT0); // see (R04)
    pick[1] = fn_active(st.input_function_assign, st.gp_s2, sscs_pkg::FN_PICK_BIT1); // see (R04)
    pick[2] = fn_active(st.input_function_assign, st.gp_s2, sscs_pkg::FN_PICK_BIT2); // see (R04)
    digital_en = fn_active(st.input_function_assign, st.gp_s2, sscs_pkg::FN_DIGITAL_EN);
  end

  // pick bit 2 is the msb of the index
  assign preset_sel = st.preset_speed[pick]; // see (R01)

  sscs_digital_decode u_decode (
    .format_i(st.parallel_cmd_format),
    .code_i(st.par_s2),
    .max_speed_i(st.max_speed),
    .speed_o(dec_speed),
    .reverse_o(dec_reverse),
    .valid_o(dec_valid)
  );

  // ==========================================================
  // register access decode
  logic setup_phase;
  logic access_phase;
  logic addr_ok;

  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= sscs_pkg::OFS_STATUS);

  function automatic logic [31:0] read_word(input sscs_state_t s, input logic [7:0] addr,
                                             input logic [2:0] pk, input logic den);
    logic [31:0] w;
    logic [7:0] rel;
    w = 32'h0000_0000;
    rel = addr - sscs_pkg::OFS_ASSIGN_BASE;
    if (addr < sscs_pkg::OFS_ASSIGN_BASE) begin
      w[15:0] = s.preset_speed[addr[4:2]];
    end else if (addr < sscs_pkg::OFS_FORMAT) begin
      w[7:0] = s.input_function_assign[rel[5:2]];
    end else if (addr == sscs_pkg::OFS_FORMAT) begin
      w[1:0] = s.parallel_cmd_format;
    end else if (addr == sscs_pkg::OFS_MAX_SPEED) begin
      w[15:0] = s.max_speed;
    end else begin
      w[sscs_pkg::ST_SPEED_LSB +: 16] = s.speed_cmd;
      w[sscs_pkg::ST_SOURCE_LSB +: 2] = s.source;
      w[sscs_pkg::ST_REVERSE] = s.speed_reverse;
      w[sscs_pkg::ST_BAD_CODE] = s.bad_code;
      w[sscs_pkg::ST_PICK_LSB +: 3] = pk;
      w[sscs_pkg::ST_DIGITAL_EN] = den;
    end
    return w;
  endfunction : read_word

  // ==========================================================
  // next state
  logic [7:0] wr_rel;
  assign wr_rel = paddr_i - sscs_pkg::OFS_ASSIGN_BASE;

  always_comb begin
    next_st = st;

    // two flops on every contact input before use
    next_st.gp_s1 = gp_in_i;
    next_st.gp_s2 = st.gp_s1;
    next_st.par_s1 = parallel_cmd_line_i; // see (R05)
    next_st.par_s2 = st.par_s1;
    next_st.run_s1 = {run_reverse_i, run_forward_i};
    next_st.run_s2 = st.run_s1;

    // read data captured in setup so the access phase answers from flops
    if (setup_phase) begin
      next_st.rdata = addr_ok ? read_word(st, paddr_i, pick, digital_en) : 32'h0000_0000;
      next_st.rerr = !addr_ok;
    end

    if (access_phase && pwrite_i && addr_ok) begin
      if (paddr_i < sscs_pkg::OFS_ASSIGN_BASE) begin
        next_st.preset_speed[paddr_i[4:2]] = pwdata_i[15:0] & sscs_pkg::PRESET_WR_MASK; // see (R01)
      end else if (paddr_i < sscs_pkg::OFS_FORMAT) begin
        next_st.input_function_assign[wr_rel[5:2]] = pwdata_i[7:0]; // see (R04)
      end else if (paddr_i == sscs_pkg::OFS_FORMAT) begin
        next_st.parallel_cmd_format = pwdata_i[1:0]; // see (R11)
      end else if (paddr_i == sscs_pkg::OFS_MAX_SPEED) begin
        next_st.max_speed = pwdata_i[15:0];
      end
    end

    // an illegal bcd digit leaves the last good command in place
    next_st.bad_code = !dec_valid;
    if (dec_valid) begin
      next_st.digital_speed = dec_speed; // see (R10)
      next_st.digital_reverse = dec_reverse;
    end

    next_st.run = st.run_s2[0] | st.run_s2[1];

    // source priority: picked preset, stored speed 0, digital lines, analog
    if (pick != 3'b000 || st.preset_speed[0] != 16'h0000) begin
      // stored speed 0 wins over both analog and digital modes
      next_st.source = sscs_pkg::SSCS_SRC_PRESET; // see (R03)
      next_st.speed_cmd = preset_sel; // see (R01)
      next_st.speed_reverse = st.run_s2[1];
    end else if (digital_en) begin
      next_st.source = sscs_pkg::SSCS_SRC_DIGITAL; // see (R05)
      next_st.speed_cmd = st.digital_speed;
      // signed reverse half flips the direction given by the run inputs
      next_st.speed_reverse = st.run_s2[1] ^ st.digital_reverse; // see (R13)
    end else begin
      next_st.source = sscs_pkg::SSCS_SRC_ANALOG; // see (R02)
      next_st.speed_cmd = analog_speed_i;
      next_st.speed_reverse = st.run_s2[1];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.gp_s1 <= 12'h000;
      st.gp_s2 <= 12'h000;
      st.par_s1 <= 12'h000;
      st.par_s2 <= 12'h000;
      st.run_s1 <= 2'b00;
      st.run_s2 <= 2'b00;
      st.preset_speed <= {sscs_pkg::NUM_PRESET{sscs_pkg::RST_PRESET}};
      st.input_function_assign <= {sscs_pkg::NUM_GP_IN{sscs_pkg::RST_ASSIGN}};
      st.parallel_cmd_format <= sscs_pkg::RST_FORMAT; // see (R11)
      st.max_speed <= sscs_pkg::RST_MAX_SPEED;
      st.digital_speed <= 16'h0000;
      st.digital_reverse <= 1'b0;
      st.bad_code <= 1'b0;
      st.speed_cmd <= 16'h0000;
      st.speed_reverse <= 1'b0;
      st.run <= 1'b0;
      st.source <= sscs_pkg::SSCS_SRC_ANALOG;
      st.rdata <= 32'h0000_0000;
      st.rerr <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // no wait states: the access phase always completes
  assign pready_o = 1'b1;
  assign prdata_o = st.rdata;
  assign pslverr_o = access_phase && st.rerr;
  assign speed_cmd_o = st.speed_cmd;
  assign speed_reverse_o = st.speed_reverse;
  assign run_o = st.run;
  assign cmd_source_o = st.source;

endmodule : sscs_speed_select

/* File: testbench/sscs_monitor.sv */
// port assertions for the speed select top.
// assumes binding onto sscs_speed_select; sees its ports only.
`timescale 1ns/100ps
module sscs_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic run_forward_i,
  input wire logic run_reverse_i,
  input wire logic [15:0] analog_speed_i,
  input wire logic [15:0] speed_cmd_o,
  input wire logic speed_reverse_o,
  input wire logic run_o,
  input wire logic [1:0] cmd_source_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // edges since reset, so $past never reaches into reset
  logic [2:0] since_rst;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_rst <= 3'h0;
    end else if (since_rst != 3'h7) begin
      since_rst <= since_rst + 3'h1;
    end
  end
  sequence s_bad_setup;
    psel_i && !penable_i && (paddr_i > 8'h58 || paddr_i[1:0] != 2'h0);
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence
  // ==========
  a_ready_always: assert property (pready_o) else $error("pready low");
  a_err_in_access: assert property (pslverr_o |-> s_access) else $error("error outside access");
  a_bad_addr_err: assert property (s_bad_setup ##1 s_access |-> pslverr_o) else $error("bad address no error");
  a_err_data_zero: assert property ((s_access and (!pwrite_i && pslverr_o)) |-> prdata_o == 32'h0000_0000)
    else $error("error read data not zero");
  a_preset_masked: assert property ((s_access and (!pwrite_i && paddr_i < 8'h20)) |-> prdata_o[31:15] == 17'h0_0000)
    else $error("preset read above 32767");
  a_preset_bound: assert property (cmd_source_o == sscs_pkg::SSCS_SRC_PRESET |-> !speed_cmd_o[15])
    else $error("preset command above 32767");
  a_analog_follow: assert property (since_rst > 3'h2 && cmd_source_o == sscs_pkg::SSCS_SRC_ANALOG
    |-> speed_cmd_o == $past(analog_speed_i)) else $error("analog not followed");
  a_run_delay: assert property (since_rst == 3'h7
    |-> run_o == ($past(run_forward_i, 3) || $past(run_reverse_i, 3))) else $error("run output wrong");
  a_source_legal: assert property (cmd_source_o != 2'h3) else $error("illegal source");
endmodule : sscs_monitor

bind sscs_speed_select sscs_monitor u_mon (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .run_forward_i, .run_reverse_i, .analog_speed_i, .speed_cmd_o,
  .speed_reverse_o, .run_o, .cmd_source_o);

/* File: testbench/sscs_ctrl_model.sv */
// controller model driving the contact lines.
// assumes bcd digits handed over nibble packed, units lowest.
`timescale 1ns/100ps
module sscs_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] code_i,
  input wire logic [11:0] gp_i,
  output logic [11:0] parallel_cmd_line_o,
  output logic [11:0] gp_in_o
);
  // lsb on line 1, closed contact is one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      parallel_cmd_line_o <= 12'h000;
      gp_in_o <= 12'h000;
    end else begin
      parallel_cmd_line_o <= code_i;
      gp_in_o <= gp_i;
    end
  end
endmodule : sscs_ctrl_model

/* File: testbench/tb.sv */
// bench for the speed select top: registers, decode table, preset and analog paths.
// assumes the controller model drives the contacts and the monitor is bound.
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [1:0] fmt; logic [11:0] code; logic [15:0] spd; logic rev;} sscs_row_t;
  localparam logic [31:0] zero_w = 32'h0000_0000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] code = 12'h000;
  logic [11:0] gp = 12'h000;
  logic [11:0] lines;
  logic [11:0] gp_in;
  logic fwd = 1'b0;
  logic rev = 1'b0;
  logic [15:0] analog = 16'h0000;
  logic [15:0] spd;
  logic spd_rev;
  logic run;
  logic [1:0] src;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int n_tests = 0;
  sscs_row_t rows [14] = '{'{2'h2, 12'h099, 16'h2710, 1'b0}, '{2'h2, 12'h001, 16'h0065, 1'b0},
    '{2'h2, 12'h098, 16'h26AA, 1'b0}, '{2'h3, 12'h999, 16'h2710, 1'b0}, '{2'h3, 12'h001, 16'h000A, 1'b0},
    '{2'h3, 12'h998, 16'h2705, 1'b0}, '{2'h1, 12'hFFF, 16'h2710, 1'b0}, '{2'h1, 12'h001, 16'h0002, 1'b0},
    '{2'h1, 12'hFFE, 16'h270D, 1'b0}, '{2'h0, 12'h800, 16'h0000, 1'b0}, '{2'h0, 12'h801, 16'h0004, 1'b0},
    '{2'h0, 12'h7FF, 16'h0004, 1'b1}, '{2'h0, 12'h000, 16'h2710, 1'b1}, '{2'h0, 12'hFFE, 16'h270B, 1'b0}};

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  sscs_speed_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .gp_in_i(gp_in), .parallel_cmd_line_i(lines), .run_forward_i(fwd),
    .run_reverse_i(rev), .analog_speed_i(analog), .speed_cmd_o(spd), .speed_reverse_o(spd_rev),
    .run_o(run), .cmd_source_o(src));
  sscs_ctrl_model u_ctrl (.clk_i(clk_i), .rst_i(rst_i), .code_i(code), .gp_i(gp),
    .parallel_cmd_line_o(lines), .gp_in_o(gp_in));

  // ==========
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic final_report();
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // ==========
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, 8'h50, zero_w, rd, er);
    chk(rd, zero_w);
    apb(1'b0, 8'h54, zero_w, rd, er);
    chk(rd, 32'h0000_2710);
    apb(1'b0, 8'h00, zero_w, rd, er);
    chk(rd, zero_w);
    apb(1'b0, 8'h5C, zero_w, rd, er);
    chk(32'(er), 32'h0000_0001);
    apb(1'b1, 8'h20, 32'(sscs_pkg::FN_DIGITAL_EN), rd, er);
    gp <= 12'h001;
    foreach (rows[i]) begin
      apb(1'b1, 8'h50, 32'(rows[i].fmt), rd, er);
      code <= rows[i].code;
      repeat (6) @(posedge clk_i);
      chk(32'(spd), 32'(rows[i].spd));
      chk(32'(spd_rev), 32'(rows[i].rev));
      chk(32'(src), 32'(sscs_pkg::SSCS_SRC_DIGITAL));
    end
    // illegal tens digit must leave the last good command
    apb(1'b1, 8'h50, 32'(sscs_pkg::FMT_BCD3), rd, er);
    code <= 12'h001;
    repeat (6) @(posedge clk_i);
    code <= 12'h9A9;
    repeat (6) @(posedge clk_i);
    chk(32'(spd), 32'h0000_000A);
    apb(1'b0, sscs_pkg::OFS_STATUS, zero_w, rd, er);
    chk(32'(rd[19]), 32'h0000_0001);
    gp <= 12'h000;
    analog <= 16'h1234;
    repeat (6) @(posedge clk_i);
    chk(32'(spd), 32'h0000_1234);
    chk(32'(src), 32'(sscs_pkg::SSCS_SRC_ANALOG));
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, 8'h20 + 8'(4 * k), 32'(8'h0A + 8'(k)), rd, er);
    end
    for (int p = 1; p < 8; p++) begin
      apb(1'b1, 8'(4 * p), (p == 7) ? 32'hFFFF_FFFF : 32'(16'h0100 + 16'(p)), rd, er);
    end
    apb(1'b0, 8'h1C, zero_w, rd, er);
    chk(rd, 32'h0000_7FFF);
    for (int p = 1; p < 8; p++) begin
      gp <= 12'(p << 1);
      repeat (6) @(posedge clk_i);
      chk(32'(spd), (p == 7) ? 32'h0000_7FFF : 32'(16'h0100 + 16'(p)));
      chk(32'(src), 32'(sscs_pkg::SSCS_SRC_PRESET));
    end
    apb(1'b1, 8'h00, 32'h0000_0200, rd, er);
    gp <= 12'h001;
    fwd <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(32'(spd), 32'h0000_0200);
    chk(32'(src), 32'(sscs_pkg::SSCS_SRC_PRESET));
    chk(32'(run), 32'h0000_0001);
    fwd <= 1'b0;
    rev <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(32'(spd_rev), 32'h0000_0001);
    // mid-run reset brings outputs and settings back to their reset values
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'(spd), 32'h0000_0000);
    chk(32'(src), 32'(sscs_pkg::SSCS_SRC_ANALOG));
    apb(1'b0, sscs_pkg::OFS_FORMAT, zero_w, rd, er);
    chk(rd, 32'(sscs_pkg::FMT_SIGNED));
    apb(1'b0, 8'h00, zero_w, rd, er);
    chk(rd, zero_w);
    final_report();
  end

  // run needs well under a thousand cycles
  initial begin
    #40000;
    fails++;
    final_report();
  end
endmodule : tb
